// ==== hw/uart_pkg.sv ====
// Shared constants and types for the serial channel
package uart_pkg;
    // ***********************************************
    // Register map (byte addresses)
    // ***********************************************
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_TXDATA = 8'h08;
    localparam logic [7:0] REG_RXDATA = 8'h0c;
    localparam logic [7:0] REG_DIV    = 8'h10;

    // ***********************************************
    // Control fields
    // ***********************************************
    localparam int         CTRL_W        = 5;
    localparam int         CTRL_TX_EN    = 0;
    localparam int         CTRL_RX_EN    = 1;
    localparam int         CTRL_LOOP     = 2;
    localparam int         CTRL_RTS_FILL = 3;
    localparam int         CTRL_STOP2    = 4;
    localparam int         CTRL_PWRDN    = 5;   // Command bit; reads back as the stopped flag
    localparam logic [4:0] CTRL_RESET    = 5'h03;

    // ***********************************************
    // Status fields
    // ***********************************************
    localparam int ST_OVR  = 4;
    localparam int ST_FERR = 5;

    // ***********************************************
    // Timing and framing
    // ***********************************************
    localparam logic [15:0] DIV_RESET    = 16'h0010;
    localparam logic [15:0] DIV_MIN      = 16'h0001;
    localparam int          DATA_W       = 8;
    localparam logic [2:0]  TX_LAST_BIT  = 3'h7;
    localparam logic [3:0]  RX_LAST_DATA = 4'h8;
    localparam logic [3:0]  RX_STOP_IDX  = 4'h9;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_START = 2'b01,
        TX_DATA  = 2'b11,
        TX_STOP  = 2'b10
    } tx_state_e;
endpackage

// ==== hw/fifo_if.sv ====
// Valid/ready carrier between the channel and its receive queue
`timescale 1ns/1ps
`default_nettype none
interface fifo_if #(parameter int WIDTH = 8, parameter int LVL_W = 5);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;
    logic [LVL_W-1:0] level;

    modport fill  (output push_valid, push_data, pop_ready,
                   input  push_ready, pop_valid, pop_data, level);
    modport store (input  push_valid, push_data, pop_ready,
                   output push_ready, pop_valid, pop_data, level);
endinterface
`default_nettype wire

// ==== hw/rx_fifo.sv ====
// Receive queue: flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    fifo_if.store    q
);
    localparam int AW = $clog2(DEPTH);

    // ***********************************************
    // Elaboration check
    // ***********************************************
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("rx_fifo depth must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wr_r;
    logic [AW:0]      rd_r;

    // Handshake decode
    wire do_push = q.push_valid && q.push_ready;
    wire do_pop  = q.pop_valid && q.pop_ready;

    assign q.level      = wr_r - rd_r;
    assign q.push_ready = q.level != (AW + 1)'(DEPTH);
    assign q.pop_valid  = q.level != '0;
    assign q.pop_data   = mem_r[rd_r[AW-1:0]];

    // Pointers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (do_push) wr_r <= wr_r + 1'b1;
            if (do_pop) rd_r <= rd_r + 1'b1;
        end
    end

    // Storage
    always_ff @(posedge core_clk) begin
        if (do_push) mem_r[wr_r[AW-1:0]] <= q.push_data;
    end
endmodule
`default_nettype wire

// ==== hw/uart_channel.sv ====
// Asynchronous serial channel with APB registers and receive queue
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module uart_channel
    import uart_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int RTS_LEVEL  = 14
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             serial_tx_out,
    input  wire logic        serial_rx_in,
    input  wire logic        clear_to_send_in,
    output logic             request_to_send_out
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;
    localparam logic [LW-1:0] RTS_LVL = LW'(RTS_LEVEL);

    // ***********************************************
    // Elaboration check
    // ***********************************************
    generate
        if (RTS_LEVEL < 1 || RTS_LEVEL > FIFO_DEPTH) begin : g_bad_rts
            $error("RTS_LEVEL must lie between 1 and FIFO_DEPTH");
        end
    endgenerate

    logic              pready_r;
    logic [31:0]       prdata_r;
    logic              pslverr_r;
    logic [CTRL_W-1:0] ctrl_r;
    logic [15:0]       div_r;
    logic [7:0]        tx_hold_r;
    logic              tx_full_r, ovr_r, ferr_r, stopped_r;
    logic [15:0]       div_cnt_r;
    logic              sclk_r;
    tx_state_e         tx_state_r, tx_state_nxt;
    logic [7:0]        tx_shift_r;
    logic [2:0]        tx_bit_r;
    logic              tx_line_r, tx_line_nxt;
    logic              stop_cnt_r;
    logic              serial_tx_out_r;
    logic              rts_r;
    logic              rx_s1_r, rx_s2_r, rx_s3_r, rx_f_r;
    logic              cts_s1_r, cts_s2_r, cts_s3_r, cts_ok_r;
    logic              rx_busy_r;
    logic [3:0]        rx_cnt_r;
    logic [16:0]       rx_timer_r;
    logic [7:0]        rx_shift_r;

    fifo_if #(.WIDTH(DATA_W), .LVL_W(LW)) rxq ();

    rx_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rxq (
        .core_clk (core_clk),
        .rst      (rst),
        .q        (rxq.store)
    );

    // ***********************************************
    // APB slave decode
    // ***********************************************
    wire setup_ph   = psel && penable && !pready_r;
    wire done_ph    = psel && penable && pready_r;
    wire wr_done    = done_ph && pwrite;
    wire rd_done    = done_ph && !pwrite;
    wire sel_ctrl   = paddr == REG_CTRL;
    wire sel_status = paddr == REG_STATUS;
    wire sel_txdata = paddr == REG_TXDATA;
    wire sel_rxdata = paddr == REG_RXDATA;
    wire sel_div    = paddr == REG_DIV;
    wire mapped     = sel_ctrl | sel_status | sel_txdata | sel_rxdata | sel_div;

    // Channel controls and status word
    wire        loop_en   = ctrl_r[CTRL_LOOP];
    wire        fill_mode = ctrl_r[CTRL_RTS_FILL];
    wire        tx_busy   = tx_state_r != TX_IDLE;
    wire [31:0] status_w  = 32'({rxq.level, stopped_r, cts_ok_r, ferr_r, ovr_r,
                                 !rxq.push_ready, rxq.pop_valid, tx_busy, tx_full_r});
    wire [7:0]  rx_head   = rxq.pop_valid ? rxq.pop_data : 8'h00;
    wire [31:0] rd_mux    = sel_ctrl   ? 32'({stopped_r, ctrl_r}) :
                            sel_status ? status_w :
                            sel_rxdata ? 32'(rx_head) :
                            sel_div    ? 32'(div_r) :
                            32'h0000_0000;

    // Two-cycle access: answer on the cycle after setup
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= setup_ph;
            prdata_r  <= setup_ph && !pwrite ? rd_mux : 32'h0000_0000;
            pslverr_r <= setup_ph && !mapped;
        end
    end

    // ***********************************************
    // Pin synchronisers: change counts when stages 2 and 3 agree
    // ***********************************************
    wire rx_edge = (rx_s2_r == rx_s3_r) && (rx_s3_r != rx_f_r);
    wire cts_new = (cts_s2_r == cts_s3_r) ? cts_s3_r : cts_ok_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {rx_s1_r, rx_s2_r, rx_s3_r, rx_f_r} <= 4'hf;
            {cts_s1_r, cts_s2_r, cts_s3_r, cts_ok_r} <= 4'h0;
        end else begin
            {rx_s1_r, rx_s2_r, rx_s3_r} <= {serial_rx_in, rx_s1_r, rx_s2_r};
            {cts_s1_r, cts_s2_r, cts_s3_r} <= {clear_to_send_in, cts_s1_r, cts_s2_r};
            if (rx_s2_r == rx_s3_r) rx_f_r <= rx_s3_r;
            cts_ok_r <= cts_new;
        end
    end

    // ***********************************************
    // Software registers and sticky flags
    // ***********************************************
    wire        tick         = !stopped_r && div_cnt_r == 16'h0000;
    wire        fall_tick    = tick && sclk_r;
    wire        tx_take      = tx_state_r == TX_IDLE && fall_tick && tx_full_r && cts_ok_r && ctrl_r[CTRL_TX_EN];
    wire        rx_push      = rxq.push_valid && rxq.push_ready;
    wire        rx_drop      = rxq.push_valid && !rxq.push_ready;
    wire        rx_src       = loop_en ? tx_line_r : rx_f_r;
    wire        rx_go        = ctrl_r[CTRL_RX_EN] && !stopped_r;
    wire        rx_start     = rx_go && !rx_busy_r && !rx_src;
    wire        rx_sample    = rx_busy_r && rx_timer_r == 17'h00000;
    wire        rx_at_stop   = rx_cnt_r == RX_STOP_IDX;
    wire        rx_frame_bad = rx_sample && rx_at_stop && !rx_src;
    wire [16:0] rx_bit_len   = {div_r, 1'b0} - 17'h00001;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_r    <= CTRL_RESET;
            div_r     <= DIV_RESET;
            tx_hold_r <= 8'h00;
            tx_full_r <= 1'b0;
            ovr_r     <= 1'b0;
            ferr_r    <= 1'b0;
            stopped_r <= 1'b0;
        end else begin
            if (wr_done && sel_ctrl) ctrl_r <= pwdata[CTRL_W-1:0];
            if (wr_done && sel_div) div_r <= pwdata[15:0] < DIV_MIN ? DIV_MIN : pwdata[15:0];
            if (wr_done && sel_txdata && !tx_full_r) begin
                tx_hold_r <= pwdata[7:0];
                tx_full_r <= 1'b1;
            end else if (tx_take) begin
                tx_full_r <= 1'b0;
            end
            // Set wins over write-one-to-clear
            ovr_r  <= rx_drop || (ovr_r && !(wr_done && sel_status && pwdata[ST_OVR]));
            ferr_r <= rx_frame_bad || (ferr_r && !(wr_done && sel_status && pwdata[ST_FERR]));
            if (rx_edge) stopped_r <= 1'b0;
            else if (wr_done && sel_ctrl && pwdata[CTRL_PWRDN]) stopped_r <= 1'b1;
        end
    end

    // ***********************************************
    // Serial clock: divider ticks toggle the serial clock
    // ***********************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_cnt_r <= 16'h0000;
            sclk_r    <= 1'b0;
        end else if (!stopped_r) begin
            div_cnt_r <= tick ? div_r - DIV_MIN : div_cnt_r - 16'h0001;
            if (tick) sclk_r <= !sclk_r;
        end
    end

    // ***********************************************
    // Transmitter
    // ***********************************************
    always_comb begin
        tx_state_nxt = tx_state_r;
        tx_line_nxt  = tx_line_r;
        if (fall_tick) begin
            unique case (tx_state_r)
                TX_IDLE: begin
                    tx_line_nxt = 1'b1;
                    if (tx_take) begin
                        tx_state_nxt = TX_START;
                        tx_line_nxt  = 1'b0;
                    end
                end
                TX_START: begin
                    tx_state_nxt = TX_DATA;
                    tx_line_nxt  = tx_shift_r[0];
                end
                TX_DATA: begin
                    if (tx_bit_r == TX_LAST_BIT) begin
                        tx_state_nxt = TX_STOP;
                        tx_line_nxt  = 1'b1;
                    end else begin
                        tx_line_nxt = tx_shift_r[0];
                    end
                end
                TX_STOP: begin
                    tx_line_nxt = 1'b1;
                    if (stop_cnt_r == ctrl_r[CTRL_STOP2]) tx_state_nxt = TX_IDLE;
                end
            endcase
        end
    end

    // Shift register advances after each bit is driven
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_state_r <= TX_IDLE;
            tx_line_r  <= 1'b1;
            tx_shift_r <= 8'h00;
            tx_bit_r   <= 3'h0;
            stop_cnt_r <= 1'b0;
        end else begin
            tx_state_r <= tx_state_nxt;
            tx_line_r  <= tx_line_nxt;
            if (tx_take) tx_shift_r <= tx_hold_r;
            else if (fall_tick && tx_state_r != TX_IDLE) tx_shift_r <= tx_shift_r >> 1;
            if (fall_tick && tx_state_r == TX_DATA) tx_bit_r <= tx_bit_r + 3'h1;
            if (fall_tick) stop_cnt_r <= tx_state_r == TX_STOP ? !stop_cnt_r : 1'b0;
        end
    end

    // ***********************************************
    // Receiver: mid-bit sampling from the start edge
    // ***********************************************
    assign rxq.push_valid = rx_sample && rx_at_stop && rx_src;
    assign rxq.push_data  = rx_shift_r;
    assign rxq.pop_ready  = rd_done && sel_rxdata;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_busy_r  <= 1'b0;
            rx_cnt_r   <= 4'h0;
            rx_timer_r <= 17'h00000;
            rx_shift_r <= 8'h00;
        end else if (rx_start) begin
            rx_busy_r  <= 1'b1;
            rx_cnt_r   <= 4'h0;
            rx_timer_r <= 17'(div_r - DIV_MIN);
        end else if (rx_sample) begin
            rx_timer_r <= rx_bit_len;
            rx_cnt_r   <= rx_cnt_r + 4'h1;
            if (rx_cnt_r != 4'h0 && rx_cnt_r <= RX_LAST_DATA) rx_shift_r <= {rx_src, rx_shift_r[7:1]};
            if (rx_at_stop || (rx_cnt_r == 4'h0 && rx_src)) rx_busy_r <= 1'b0;
        end else if (rx_busy_r) begin
            rx_timer_r <= rx_timer_r - 17'h00001;
        end
    end

    // ***********************************************
    // Pin outputs
    // ***********************************************
    wire rts_nxt = fill_mode ? rxq.level < RTS_LVL : tx_full_r || tx_busy;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            serial_tx_out_r <= 1'b1;
            rts_r           <= 1'b0;
        end else begin
            serial_tx_out_r <= tx_line_nxt || loop_en;
            rts_r           <= rts_nxt;
        end
    end

    assign pready              = pready_r;
    assign prdata              = prdata_r;
    assign pslverr             = pslverr_r;
    assign serial_tx_out       = serial_tx_out_r;
    assign request_to_send_out = rts_r;

    // ***********************************************
    // Assertions
    // ***********************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_idle_mark;
        (tx_state_r == TX_IDLE) [*2] |-> serial_tx_out;
    endproperty
    a_idle_mark: assert property (p_idle_mark) else $error("Line not at mark while idle");
    property p_loop_mark;
        $past(loop_en) |-> serial_tx_out;
    endproperty
    a_loop_mark: assert property (p_loop_mark) else $error("Line not at mark in loopback");
    property p_fall_only;
        ($changed(tx_line_r)) |-> $past(fall_tick);
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("Line changed off a falling edge");
    property p_lsb_first;
        (fall_tick && tx_state_r == TX_START) |=> tx_line_r == $past(tx_shift_r[0]);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("First data bit is not the LSB");
    property p_start_low;
        (tx_state_r == TX_IDLE ##1 tx_state_r == TX_START) |-> !tx_line_r && $past(cts_ok_r);
    endproperty
    a_start_low: assert property (p_start_low) else $error("Bad start bit or start without grant");
    property p_stop_high;
        (tx_state_r == TX_STOP) |-> tx_line_r;
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("Stop bit not high");
    property p_wake;
        (stopped_r && rx_edge) |=> !stopped_r;
    endproperty
    a_wake: assert property (p_wake) else $error("Receive edge did not restart the clock");
    property p_rts_fill;
        (fill_mode && rxq.level >= RTS_LVL) |=> !request_to_send_out;
    endproperty
    a_rts_fill: assert property (p_rts_fill) else $error("Request-to-send held with queue near full");
    property p_rts_auto;
        (!fill_mode && tx_busy) |=> request_to_send_out;
    endproperty
    a_rts_auto: assert property (p_rts_auto) else $error("Request-to-send low during a frame");

    c_frame_sent:  cover property (tx_state_r == TX_STOP ##1 tx_state_r == TX_IDLE);
    c_frame_recvd: cover property (rx_push);
    c_queue_full:  cover property (rx_drop);
    c_wake:        cover property (stopped_r ##1 !stopped_r);
endmodule
`default_nettype wire

// ==== dv/serial_partner.sv ====
// Remote serial transceiver model facing the channel's pins
`timescale 1ns/1ps
`default_nettype none
module serial_partner #(
    parameter int BIT = 4
) (
    input  wire logic core_clk,
    input  wire logic serial_tx_out,
    output var logic serial_rx_in,
    output var logic [7:0] got_byte,
    output var int   got_count,
    output var int   bad_count
);
    // ******************
    // Frame receiver
    // ******************
    // Mid-bit sampling of the transmit line, LSB first
    initial begin
        logic [7:0] b;
        serial_rx_in = 1'b1;
        got_byte = 8'h00;
        got_count = 0;
        bad_count = 0;
        b = 8'h00;
        forever begin
            @(posedge core_clk);
            if (serial_tx_out === 1'b0) begin
                repeat (BIT / 2) @(posedge core_clk);
                if (serial_tx_out !== 1'b0) bad_count++;
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT) @(posedge core_clk);
                    b[i] = serial_tx_out;
                end
                repeat (BIT) @(posedge core_clk);
                if (serial_tx_out !== 1'b1) bad_count++;
                got_byte = b;
                got_count++;
            end
        end
    end

    // ******************
    // Frame sender
    // ******************
    // Start, data LSB first, stop, then idle at mark
    task automatic send_byte(input logic [7:0] b);
        @(posedge core_clk);
        serial_rx_in <= 1'b0;
        repeat (BIT) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            serial_rx_in <= b[i];
            repeat (BIT) @(posedge core_clk);
        end
        serial_rx_in <= 1'b1;
        repeat (3 * BIT) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the serial channel
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import uart_pkg::*;
    logic        core_clk, rst, psel, penable, pwrite, cts, err;
    logic [7:0]  paddr, got;
    logic [31:0] pwdata, rd;
    wire  logic  pready, pslverr, tx, rx, rts;
    wire  logic [31:0] prdata;
    int          errors = 0, n_tests = 0, got_n, bad_n;

    uart_channel #(.FIFO_DEPTH(16), .RTS_LEVEL(14)) dut (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .serial_tx_out(tx),
        .serial_rx_in(rx), .clear_to_send_in(cts), .request_to_send_out(rts));
    // Bit time is 2*DIV cycles with DIV set to 2
    serial_partner #(.BIT(4)) partner (
        .core_clk(core_clk), .serial_tx_out(tx), .serial_rx_in(rx),
        .got_byte(got), .got_count(got_n), .bad_count(bad_n));

    // Clock source
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // ******************
    // Bus and check tasks
    // ******************
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            errors++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        check(nm, e, rd & m);
    endtask

    task automatic wait_byte(input int n);
        int k;
        k = 0;
        while (got_n < n && k < 400) begin
            @(posedge core_clk);
            k++;
        end
        if (k >= 400) begin
            errors++;
            end_of_test();
        end
    endtask

    task automatic end_of_test();
        $display("counts errors %0d checks %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ******************
    // Test sequence
    // ******************
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cts = 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        check("tx idle", 1, tx);
        check("rts reset", 0, rts);
        rdc(REG_CTRL, 32'h1f, 32'h03, "ctrl");
        rdc(REG_DIV, 32'hffff, 32'h10, "div");
        apb(1'b0, 8'h20, 32'h0);
        check("slverr", 1, err);
        $display("test reset done");
        // Transmit with automatic request-to-send
        apb(1'b1, REG_DIV, 32'h2);
        apb(1'b1, REG_TXDATA, 32'ha5);
        repeat (3) @(posedge core_clk);
        check("rts busy", 1, rts);
        wait_byte(1);
        check("tx byte", 8'ha5, got);
        check("framing", 0, bad_n);
        repeat (8) @(posedge core_clk);
        check("rts idle", 0, rts);
        check("tx mark", 1, tx);
        $display("test transmit done");
        // Clear-to-send withheld then granted
        cts <= 1'b0;
        apb(1'b1, REG_TXDATA, 32'h81);
        repeat (60) @(posedge core_clk);
        check("held", 1, got_n);
        cts <= 1'b1;
        wait_byte(2);
        check("granted", 8'h81, got);
        $display("test cts done");
        // Receive, then fill the queue until it overruns
        partner.send_byte(8'h3c);
        rdc(REG_RXDATA, 32'hff, 32'h3c, "rx byte");
        apb(1'b1, REG_CTRL, 32'h0b);
        for (int i = 0; i < 17; i++) begin
            partner.send_byte(i[7:0]);
            if (i == 12) check("rts low fill", 1, rts);
            if (i == 13) check("rts threshold", 0, rts);
        end
        rdc(REG_STATUS, 32'h1f1c, 32'h101c, "full status");
        for (int i = 0; i < 16; i++) rdc(REG_RXDATA, 32'hff, i, "drain");
        rdc(REG_RXDATA, 32'hff, 32'h0, "empty");
        repeat (3) @(posedge core_clk);
        check("rts drained", 1, rts);
        apb(1'b1, REG_STATUS, 32'h10);
        rdc(REG_STATUS, 32'h10, 32'h0, "overrun clear");
        $display("test fill done");
        // Loopback keeps the pin at mark
        apb(1'b1, REG_CTRL, 32'h07);
        apb(1'b1, REG_TXDATA, 32'h5a);
        repeat (60) @(posedge core_clk);
        check("loop pin", 2, got_n);
        check("loop mark", 1, tx);
        rdc(REG_RXDATA, 32'hff, 32'h5a, "loop byte");
        $display("test loopback done");
        // Power-down and wake on receive activity
        apb(1'b1, REG_CTRL, 32'h23);
        rdc(REG_STATUS, 32'h80, 32'h80, "stopped");
        partner.send_byte(8'hf0);
        rdc(REG_STATUS, 32'h80, 32'h0, "woken");
        $display("test power-down done");
        // Two stop bits keep the frame busy one bit time longer
        apb(1'b1, REG_CTRL, 32'h13);
        apb(1'b1, REG_TXDATA, 32'hc3);
        wait_byte(3);
        check("two stop byte", 8'hc3, got);
        check("two stop framing", 0, bad_n);
        repeat (3) @(posedge core_clk);
        check("two stop busy", 1, rts);
        repeat (4) @(posedge core_clk);
        check("two stop end", 0, rts);
        $display("test two stop done");
        end_of_test();
    end
endmodule
`default_nettype wire
